// ### cca_top.sv
// Five capture/compare modules on a shared 16-bit counter, Wishbone slave.
// Assumes pins and external timebase sources are asynchronous to clk.
//
// Chosen here: the Wishbone register port and the register offsets.
`default_nettype none
module cca_top
  import cca_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [ADDR_W-1:0]      wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   timer_ovf_pulse,
  input  wire logic                   ext_count_pin,
  input  wire logic                   ext_osc_clk,
  input  wire logic [NUM_MODULES-1:0] module_io_pin_i,
  output logic      [NUM_MODULES-1:0] module_io_pin_o,
  output logic      [NUM_MODULES-1:0] module_io_pin_oe_n,
  output logic                        irq
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [7:0]             ctrl_r;
  logic [15:0]            count_r;
  logic                   ovf_flag_r;
  logic [NUM_MODULES-1:0] module_event_flag_r;
  cca_mode_t              mode_r  [NUM_MODULES];
  logic [7:0]             cmpl_r  [NUM_MODULES];
  logic [7:0]             cmph_r  [NUM_MODULES];
  logic [NUM_MODULES-1:0] pin_r;
  logic [7:0]             snap_hi_r;

  // ---------------------------------------------------------------------------
  // Wishbone decode
  // ---------------------------------------------------------------------------
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] wdat;
  assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wdat   = wb_dat_i[7:0];

  // Ack one cycle after the request, dropped the following cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_stb && wb_adr_i == OFS_CTRL) begin
      ctrl_r <= wdat;
    end
  end

  // ---------------------------------------------------------------------------
  // Synchronisers for asynchronous inputs
  // ---------------------------------------------------------------------------
  logic [NUM_MODULES+1:0] sync1_r;
  logic [NUM_MODULES+1:0] sync2_r;
  logic [NUM_MODULES+1:0] sync3_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= {ext_osc_clk, ext_count_pin, module_io_pin_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------------------
  logic [3:0] pre_r;
  logic [2:0] osc_div_r;
  logic       tick;
  logic       osc_rise;
  logic       ext_fall;
  assign osc_rise = sync2_r[NUM_MODULES+1] && !sync3_r[NUM_MODULES+1];
  assign ext_fall = !sync2_r[NUM_MODULES] && sync3_r[NUM_MODULES];

  // Prescalers for the divide-by-12/4 and external divide-by-8 sources
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r     <= '0;
      osc_div_r <= '0;
    end else begin
      if ((ctrl_r[CTRL_TB_LSB +: 3] == TB_DIV12 && pre_r == DIV12_CNT) ||
          (ctrl_r[CTRL_TB_LSB +: 3] == TB_DIV4 && pre_r >= DIV4_CNT)) begin
        pre_r <= '0;
      end else begin
        pre_r <= pre_r + 4'h1;
      end
      if (osc_rise) begin
        osc_div_r <= osc_div_r + 3'h1;
      end
    end
  end

  // Select the tick enable
  always_comb begin
    unique case (ctrl_r[CTRL_TB_LSB +: 3])
      TB_DIV12:  tick = (pre_r == DIV12_CNT);
      TB_DIV4:   tick = (pre_r >= DIV4_CNT);
      TB_TIMER:  tick = timer_ovf_pulse;
      TB_EXTPIN: tick = ext_fall;
      TB_SYSCLK: tick = 1'b1;
      TB_EXTDIV: tick = osc_rise && (osc_div_r == DIV8_CNT);
      default:   tick = 1'b0;
    endcase
  end

  logic step;
  assign step = tick && ctrl_r[CTRL_RUN_BIT];

  // ---------------------------------------------------------------------------
  // Shared counter
  // ---------------------------------------------------------------------------
  // Up-count with wrap; software may also load either byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= COUNT_RST;
    end else if (wr_stb && wb_adr_i == OFS_COUNT_LO) begin
      count_r[7:0] <= wdat;
    end else if (wr_stb && wb_adr_i == OFS_COUNT_HI) begin
      count_r[15:8] <= wdat;
    end else if (step) begin
      count_r <= count_r + 16'h0001;
    end
  end

  logic ovf16;
  logic ovf8;
  assign ovf16 = step && count_r == 16'hffff;
  assign ovf8  = step && count_r[7:0] == 8'hff;

  // Overflow flag: set wins over software clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf16) begin
      ovf_flag_r <= 1'b1;
    end else if (wr_stb && wb_adr_i == OFS_FLAGS) begin
      ovf_flag_r <= wdat[FLAGS_OVF_BIT];
    end
  end

  // High byte snapshot taken on a low byte read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_hi_r <= '0;
    end else if (rd_stb && wb_adr_i == OFS_COUNT_LO) begin
      snap_hi_r <= count_r[15:8];
    end
  end

  // ---------------------------------------------------------------------------
  // Capture/compare modules
  // ---------------------------------------------------------------------------
  logic [NUM_MODULES-1:0] evt;
  logic [NUM_MODULES-1:0] irq_req;

  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : g_mod
      localparam logic [ADDR_W-1:0] A_MODE = OFS_MODE_BASE + ADDR_W'(4 * g);
      localparam logic [ADDR_W-1:0] A_CMPL = OFS_CMPL_BASE + ADDR_W'(4 * g);
      localparam logic [ADDR_W-1:0] A_CMPH = OFS_CMPH_BASE + ADDR_W'(4 * g);
      cca_mode_t  m;
      cca_op_t    op;
      logic       cap_edge;
      logic       match16;
      logic       match8;
      logic       wr_mode;
      logic       wr_l;
      logic       wr_h;
      logic       rise;
      logic       fall;
      assign m       = mode_r[g];
      assign wr_mode = wr_stb && wb_adr_i == A_MODE;
      assign wr_l    = wr_stb && wb_adr_i == A_CMPL;
      assign wr_h    = wr_stb && wb_adr_i == A_CMPH;
      // Edges from the synchronised pin; the two-flop path resynchronises but passes on any glitch it samples
      assign rise    = sync2_r[g] && !sync3_r[g];
      assign fall    = !sync2_r[g] && sync3_r[g];
      assign match16 = step && count_r == {cmph_r[g], cmpl_r[g]};
      assign match8  = step && count_r[7:0] == cmpl_r[g];

      // Mode decode; unlisted combinations stay idle
      always_comb begin
        op = CCA_IDLE;
        if (!m.match_flag_enable && !m.toggle_enable && !m.pwm_enable &&
            (m.rise_capture_enable || m.fall_capture_enable)) begin
          op = CCA_CAPTURE;
        end else if (m.compare_enable && !m.rise_capture_enable &&
                     !m.fall_capture_enable) begin
          if (m.toggle_enable && m.pwm_enable) begin
            op = CCA_FREQ;
          end else if (m.pwm_enable) begin
            op = m.wide_pwm_select ? CCA_PWM16 : CCA_PWM8;
          end else if (m.match_flag_enable && m.toggle_enable) begin
            op = CCA_HSO;
          end else if (m.match_flag_enable) begin
            op = CCA_TIMER;
          end
        end
      end

      assign cap_edge = (op == CCA_CAPTURE) &&
                        ((m.rise_capture_enable && rise) ||
                         (m.fall_capture_enable && fall));

      // Event: capture, timer/HSO match, or match while match flag enabled in PWM or frequency mode
      always_comb begin
        unique case (op)
          CCA_CAPTURE:         evt[g] = cap_edge;
          CCA_TIMER, CCA_HSO:  evt[g] = match16;
          CCA_PWM16:           evt[g] = match16 && m.match_flag_enable;
          CCA_PWM8, CCA_FREQ:  evt[g] = match8 && m.match_flag_enable;
          default:             evt[g] = 1'b0;
        endcase
      end

      // Mode register; compare enable forced by compare byte writes
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          mode_r[g] <= MODE_RST;
        end else if (wr_mode) begin
          mode_r[g] <= wdat;
        end else if (wr_l) begin
          mode_r[g].compare_enable <= 1'b0;
        end else if (wr_h) begin
          mode_r[g].compare_enable <= 1'b1;
        end
      end

      // Compare low byte: capture, frequency step, 8-bit reload, software
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmpl_r[g] <= '0;
        end else if (wr_l) begin
          cmpl_r[g] <= wdat;
        end else if (cap_edge) begin
          cmpl_r[g] <= count_r[7:0];
        end else if (op == CCA_FREQ && match8) begin
          cmpl_r[g] <= cmpl_r[g] + cmph_r[g]; // zero wraps as 256
        end else if (op == CCA_PWM8 && ovf8) begin
          cmpl_r[g] <= cmph_r[g];
        end
      end

      // Compare high byte
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmph_r[g] <= '0;
        end else if (wr_h) begin
          cmph_r[g] <= wdat;
        end else if (cap_edge) begin
          cmph_r[g] <= count_r[15:8];
        end
      end

      // Pin output; high on match is gated off in the overflow cycle so zero stays high
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_r[g] <= 1'b0;
        end else begin
          unique case (op)
            CCA_HSO: begin
              if (match16) pin_r[g] <= !pin_r[g];
            end
            CCA_FREQ: begin
              if (match8) pin_r[g] <= !pin_r[g];
            end
            CCA_PWM8: begin
              if (step && count_r[7:0] + 8'h01 == cmpl_r[g] && !ovf8) begin
                pin_r[g] <= 1'b1;
              end else if (ovf8) begin
                pin_r[g] <= (cmph_r[g] == 8'h00);
              end
            end
            CCA_PWM16: begin
              if (step && count_r + 16'h0001 == {cmph_r[g], cmpl_r[g]} && !ovf16) begin
                pin_r[g] <= 1'b1;
              end else if (ovf16) begin
                pin_r[g] <= ({cmph_r[g], cmpl_r[g]} == 16'h0000);
              end
            end
            default: begin
              // PWM selected with compare off forces low; others hold
              if (m.pwm_enable && !m.compare_enable) pin_r[g] <= 1'b0;
            end
          endcase
        end
      end

      // Driven whenever a waveform mode is selected
      assign module_io_pin_oe_n[g] = !(op == CCA_HSO || op == CCA_FREQ ||
                                       op == CCA_PWM8 || op == CCA_PWM16 ||
                                       (m.pwm_enable && !m.compare_enable));
      assign irq_req[g] = module_event_flag_r[g] && m.event_irq_enable;
    end
  endgenerate

  assign module_io_pin_o = pin_r;

  // Event flags: hardware set wins over software write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      module_event_flag_r <= '0;
    end else if (wr_stb && wb_adr_i == OFS_FLAGS) begin
      module_event_flag_r <= wdat[NUM_MODULES-1:0] | evt;
    end else begin
      module_event_flag_r <= module_event_flag_r | evt;
    end
  end

  // Interrupt gated by array and global enables
  assign irq = ctrl_r[CTRL_GLB_IE_BIT] && ctrl_r[CTRL_ARR_IE_BIT] &&
               (|irq_req || (ovf_flag_r && ctrl_r[CTRL_OVF_IE_BIT]));

  // ---------------------------------------------------------------------------
  // Read data, registered with the ack
  // ---------------------------------------------------------------------------
  logic [7:0] rdat;
  always_comb begin
    rdat = 8'h00;
    if (wb_adr_i == OFS_CTRL)     rdat = ctrl_r;
    if (wb_adr_i == OFS_FLAGS)    rdat = {ovf_flag_r, 2'b00, module_event_flag_r};
    if (wb_adr_i == OFS_COUNT_LO) rdat = count_r[7:0];
    if (wb_adr_i == OFS_COUNT_HI) rdat = snap_hi_r;
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (wb_adr_i == OFS_MODE_BASE + ADDR_W'(4 * i)) rdat = mode_r[i];
      if (wb_adr_i == OFS_CMPL_BASE + ADDR_W'(4 * i)) rdat = cmpl_r[i];
      if (wb_adr_i == OFS_CMPH_BASE + ADDR_W'(4 * i)) rdat = cmph_r[i];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= '0;
    end else if (rd_stb) begin
      wb_dat_o <= {24'h000000, rdat};
    end
  end

endmodule
`default_nettype wire

// ### cca_pkg.sv
// Package for the counter array capture/compare block.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
`default_nettype none
package cca_pkg;
  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_MODULES = 5;
  localparam int ADDR_W      = 8;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00; // run, timebase, irq enables
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h04; // overflow and event flags
  localparam logic [ADDR_W-1:0] OFS_COUNT_LO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HI  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MODE_BASE = 8'h10; // mode reg n at base + 4n
  localparam logic [ADDR_W-1:0] OFS_CMPL_BASE = 8'h30; // low byte n at base + 4n
  localparam logic [ADDR_W-1:0] OFS_CMPH_BASE = 8'h50; // high byte n at base + 4n

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int CTRL_RUN_BIT    = 0;
  localparam int CTRL_TB_LSB     = 1; // timebase_select, 3 bits
  localparam int CTRL_OVF_IE_BIT = 4;
  localparam int CTRL_ARR_IE_BIT = 5; // array_irq_enable
  localparam int CTRL_GLB_IE_BIT = 6; // global_irq_enable
  localparam int FLAGS_OVF_BIT   = 7;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // Timebase selection and prescale counts
  // ---------------------------------------------------------------------------
  localparam logic [2:0] TB_DIV12  = 3'h0;
  localparam logic [2:0] TB_DIV4   = 3'h1;
  localparam logic [2:0] TB_TIMER  = 3'h2;
  localparam logic [2:0] TB_EXTPIN = 3'h3;
  localparam logic [2:0] TB_SYSCLK = 3'h4;
  localparam logic [2:0] TB_EXTDIV = 3'h5;
  localparam logic [3:0] DIV12_CNT = 4'hb;
  localparam logic [3:0] DIV4_CNT  = 4'h3;
  localparam logic [2:0] DIV8_CNT  = 3'h7;

  // Module mode register, bit 7 down to bit 0
  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable;
    logic rise_capture_enable;
    logic fall_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic event_irq_enable;
  } cca_mode_t;

  typedef enum logic [2:0] {
    CCA_IDLE, CCA_CAPTURE, CCA_TIMER, CCA_HSO, CCA_FREQ, CCA_PWM8, CCA_PWM16
  } cca_op_t;
endpackage
`default_nettype wire

// ### cca_monitor.sv
// Checker for the capture/compare block, bound to the top module.
// Assumes a classic Wishbone master and a single clock domain.
`default_nettype none
module cca_monitor
  import cca_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [ADDR_W-1:0]      wb_adr_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic [NUM_MODULES-1:0] module_io_pin_o,
  input wire logic [NUM_MODULES-1:0] module_io_pin_oe_n,
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]             ctrl_r;
  cca_mode_t              mode_r [NUM_MODULES];
  logic                   wr_take;
  logic [NUM_MODULES-1:0] act;
  logic [NUM_MODULES-1:0] off;
  logic [NUM_MODULES-1:0] cap;
  logic [NUM_MODULES-1:0] eccf_v;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------------------
  // Shadow of the control and mode registers
  // ---------------------------------------------------------------------------
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // Mirror every control, mode and compare byte write the block takes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
      for (int i = 0; i < NUM_MODULES; i++) mode_r[i] <= MODE_RST;
    end else begin
      if (wr_take && wb_adr_i == OFS_CTRL) ctrl_r <= wb_dat_i[7:0];
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (wr_take && wb_adr_i == OFS_CMPL_BASE + 8'(4 * i)) mode_r[i].compare_enable <= 1'b0;
        if (wr_take && wb_adr_i == OFS_CMPH_BASE + 8'(4 * i)) mode_r[i].compare_enable <= 1'b1;
        if (wr_take && wb_adr_i == OFS_MODE_BASE + 8'(4 * i)) mode_r[i] <= wb_dat_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Bus and interrupt properties
  // ---------------------------------------------------------------------------
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |->
    wb_dat_o[31:8] == 24'h000000 && (wb_adr_i < 8'h64 || wb_dat_o == 32'h00000000))
    else $error("read data not zero where it must be");
  a_irq_gated: assert property (irq |-> ctrl_r[CTRL_ARR_IE_BIT] && ctrl_r[CTRL_GLB_IE_BIT])
    else $error("interrupt without array and global enables");
  a_irq_needs_src: assert property (irq |-> ctrl_r[CTRL_OVF_IE_BIT] || (|eccf_v))
    else $error("interrupt without any source enable");
  a_irq_holds_high: assert property (irq && !wr_take |=> irq)
    else $error("interrupt dropped without a software write");

  // ---------------------------------------------------------------------------
  // Per-module pin properties
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
    assign act[g]    = mode_r[g].pwm_enable || mode_r[g].toggle_enable;
    assign off[g]    = mode_r[g].pwm_enable && !mode_r[g].toggle_enable &&
                       !mode_r[g].compare_enable && !mode_r[g].rise_capture_enable &&
                       !mode_r[g].fall_capture_enable;
    assign cap[g]    = (mode_r[g].rise_capture_enable || mode_r[g].fall_capture_enable) &&
                       !mode_r[g].match_flag_enable && !act[g];
    assign eccf_v[g] = mode_r[g].event_irq_enable;
    a_pin_idle_mode: assert property ($changed(module_io_pin_o[g]) |-> act[g] || $past(act[g]))
      else $error("pin changed outside an output mode");
    a_oe_out_mode: assert property (!module_io_pin_oe_n[g] |-> act[g] || $past(act[g]))
      else $error("pin driven outside an output mode");
    a_pwm_off_low: assert property (off[g] ##1 off[g] |-> !module_io_pin_o[g])
      else $error("pwm with compare off not low");
    a_capture_no_drive: assert property (cap[g] ##1 cap[g] |-> module_io_pin_oe_n[g])
      else $error("capture mode drives the pin");
  end
endmodule

bind cca_top cca_monitor i_cca_monitor (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .module_io_pin_o(module_io_pin_o), .module_io_pin_oe_n(module_io_pin_oe_n), .irq(irq));
`default_nettype wire

// ### cca_pin_model.sv
// Model of the signal sources and loads on the module pins.
// Assumes the bench requests levels; the model paces them to the clock.
`default_nettype none
module cca_pin_model
  import cca_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [NUM_MODULES-1:0] want,
  input  wire logic [NUM_MODULES-1:0] pin_o,
  input  wire logic [NUM_MODULES-1:0] oe_n,
  output logic      [NUM_MODULES-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_MODULES-1:0] src_r  = '0;
  logic [1:0]             hold_r = 2'h0;

  // Follow the request; each level stands two clocks or more
  always_ff @(posedge clk) begin
    if (want != src_r && hold_r >= 2'h1) begin
      src_r  <= want;
      hold_r <= 2'h0;
    end else if (hold_r != 2'h3) begin
      hold_r <= hold_r + 2'h1;
    end
  end

  // The wire shows the block's drive when enabled, else the source
  assign pin_in = (~oe_n & pin_o) | (oe_n & src_r);
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the capture/compare block.
// Assumes the pin model and the bound checker; counter runs on the system clock.
`default_nettype none
module testbench
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk, sys_rst, cyc, stb, we, ack, irq;
  logic [7:0]             adr, q;
  logic [31:0]            wdat, rdat;
  logic [3:0]             sel;
  logic [NUM_MODULES-1:0] pin_in, pin_o, oe_n, want;
  int                     n_fail = 0, checks_done = 0, cycles = 0;

  cca_top i_cca_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_ovf_pulse(1'b0), .ext_count_pin(1'b0), .ext_osc_clk(1'b0),
    .module_io_pin_i(pin_in), .module_io_pin_o(pin_o), .module_io_pin_oe_n(oe_n), .irq(irq));
  cca_pin_model i_cca_pin_model (.clk(clk), .want(want), .pin_o(pin_o), .oe_n(oe_n),
    .pin_in(pin_in));

  // Clock and run limit
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task conclude;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask
  task setc(input logic [15:0] v);
    wr(OFS_COUNT_LO, v[7:0]);
    wr(OFS_COUNT_HI, v[15:8]);
  endtask
  // Low byte first so the compare enable ends up set
  task setcmp(input int n, input logic [15:0] v);
    wr(OFS_CMPL_BASE + 8'(4 * n), v[7:0]);
    wr(OFS_CMPH_BASE + 8'(4 * n), v[15:8]);
  endtask
  task gap(output int c);
    logic p;
    p = pin_o[3];
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pin_o[3] === p && c < 600);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_regs;
    rd("ctrl reset", OFS_CTRL, CTRL_RST);
    rd("mode reset", OFS_MODE_BASE, MODE_RST);
    rd("unmapped", 8'hfc, 8'h00);
    wr(OFS_CMPH_BASE, 8'h00);
    rd("mode after high write", OFS_MODE_BASE, 8'h40);
    wr(OFS_CMPL_BASE, 8'h00);
    rd("mode after low write", OFS_MODE_BASE, 8'h00);
  endtask
  // Each selection sees a rise then a fall
  task t_capture;
    logic [7:0]  m [3];
    logic        hit;
    logic [15:0] v;
    m = '{8'h20, 8'h10, 8'h30};
    wr(OFS_CTRL, 8'h08);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_MODE_BASE, m[i]);
      for (int e = 0; e < 2; e++) begin
        v = 16'h1200 + 16'(i * 2 + e);
        setc(v);
        wr(OFS_FLAGS, 8'h00);
        want[0] <= (e == 0);
        repeat (8) @(posedge clk);
        hit = (e == 0) ? m[i][5] : m[i][4];
        rd("capture flag", OFS_FLAGS, {7'h00, hit});
        if (hit) begin
          rd("capture low", OFS_CMPL_BASE, v[7:0]);
          rd("capture high", OFS_CMPH_BASE, v[15:8]);
        end
      end
    end
  endtask
  task t_timer;
    wr(OFS_CTRL, 8'h08);
    setc(16'h0000);
    setcmp(1, 16'h0020);
    wr(OFS_MODE_BASE + 8'h04, 8'h49);
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL, 8'h09);
    repeat (60) @(posedge clk);
    rd("timer flag", OFS_FLAGS, 8'h02);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(OFS_CTRL, 8'h69);
    chk("irq raised", 16'h0001, {15'h0000, irq});
    wr(OFS_MODE_BASE + 8'h04, 8'h48);
    chk("irq event masked", 16'h0000, {15'h0000, irq});
    wr(OFS_MODE_BASE + 8'h04, 8'h49);
    wr(OFS_FLAGS, 8'h00);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask
  task t_hso;
    logic p;
    wr(OFS_CTRL, 8'h08);
    setc(16'h0000);
    setcmp(2, 16'h0030);
    wr(OFS_MODE_BASE + 8'h08, 8'h4c);
    wr(OFS_FLAGS, 8'h00);
    p = pin_o[2];
    wr(OFS_CTRL, 8'h09);
    repeat (80) @(posedge clk);
    chk("hso pin", {15'h0000, ~p}, {15'h0000, pin_o[2]});
    rd("hso flags", OFS_FLAGS, 8'h06);
  endtask
  task t_freq;
    int c;
    wr(OFS_CMPL_BASE + 8'h0c, 8'h00);
    wr(OFS_CMPH_BASE + 8'h0c, 8'h04);
    wr(OFS_MODE_BASE + 8'h0c, 8'h46);
    gap(c);
    gap(c);
    gap(c);
    chk("freq half period", 16'h0004, 16'(c));
    wr(OFS_CMPH_BASE + 8'h0c, 8'h00);
    gap(c);
    gap(c);
    gap(c);
    chk("freq zero high byte", 16'h0100, 16'(c));
  endtask
  // High cycles in 512 clocks per duty case
  task t_pwm;
    logic [7:0]  md [5];
    logic [15:0] cv [5];
    logic [15:0] c0 [5];
    logic [15:0] ex [5];
    int          h;
    md = '{8'h42, 8'h42, 8'h02, 8'hcb, 8'hc2};
    cv = '{16'hc080, 16'h0000, 16'hc080, 16'hfff0, 16'h0000};
    c0 = '{16'h0050, 16'h00f0, 16'h0050, 16'hffd0, 16'hfff0};
    ex = '{16'h00c0, 16'h0200, 16'h0000, 16'h0010, 16'h0200};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, 8'h08);
      setc(c0[i]);
      setcmp(4, cv[i]);
      wr(OFS_MODE_BASE + 8'h10, md[i]);
      wr(OFS_CTRL, 8'h09);
      repeat (24) @(posedge clk);
      h = 0;
      repeat (512) begin
        @(posedge clk);
        h += int'(pin_o[4]);
      end
      chk("pwm high cycles", ex[i], 16'(h));
      if (i == 3) rd("match flag", OFS_FLAGS, 8'h96);
    end
  endtask

  // Reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    cyc     = 1'b0;
    stb     = 1'b0;
    we      = 1'b0;
    adr     = 8'h00;
    wdat    = 32'h00000000;
    sel     = 4'hf;
    want    = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_capture();
    t_timer();
    t_hso();
    t_freq();
    t_pwm();
    conclude();
  end
endmodule
`default_nettype wire
